// ### avg_pkg.sv
// Constants, register map and types for the ADC volume and auto gain block
package avg_pkg;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 7;
	localparam int REG_W  = 9;

	localparam logic [6:0] OFS_ADC_VOL = 7'h0F;
	localparam logic [6:0] OFS_AGC1    = 7'h20;
	localparam logic [6:0] OFS_AGC2    = 7'h21;
	localparam logic [6:0] OFS_AGC3    = 7'h22;
	localparam logic [6:0] OFS_PGA     = 7'h2D;

	// ==========================================================
	// Field positions
	localparam int EN_BIT     = 8;
	localparam int MODE_BIT   = 8;
	localparam int FLOOR_LSB  = 0;
	localparam int CEIL_LSB   = 3;
	localparam int LEVEL_LSB  = 0;
	localparam int HOLD_LSB   = 4;
	localparam int RISE_LSB   = 4;
	localparam int FALL_LSB   = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_VOL   = 8'hFF;
	localparam logic [2:0] RST_FLOOR = 3'h0;
	localparam logic [2:0] RST_CEIL  = 3'h7;
	localparam logic [3:0] RST_LEVEL = 4'hB;
	localparam logic [3:0] RST_HOLD  = 4'h0;
	localparam logic [3:0] RST_RISE  = 4'h3;
	localparam logic [3:0] RST_FALL  = 4'h2;
	localparam logic [5:0] RST_PGA   = 6'h10;

	// ==========================================================
	// Gain arithmetic
	localparam logic [7:0] VOL_MUTE   = 8'h00;
	localparam logic [8:0] VOL_TOP    = 9'h0FF;
	localparam logic [8:0] HALF_PER_SH = 9'h00C;
	localparam logic [3:0] LEVEL_SAT  = 4'hE;
	localparam logic [8:0] LEVEL_TOP  = 9'h00F;
	localparam logic [8:0] LEVEL_STEP = 9'h003;
	localparam logic [2:0] CEIL_FILL  = 3'h7;
	localparam logic [2:0] FLOOR_FILL = 3'h0;
	localparam logic [3:0] RATE_SAT   = 4'hA;
	localparam int         Q_FRAC     = 15;
	// 10^(-r/40) in Q15, one entry per half-decibel inside 6 dB
	localparam logic [15:0] FRAC_TAB [12] = '{
		16'h8000, 16'h78D7, 16'h7215, 16'h6BB3,
		16'h65AD, 16'h5FFD, 16'h5A9E, 16'h558D,
		16'h50C3, 16'h4C3F, 16'h47FB, 16'h43F4};

	// ==========================================================
	// Timing
	localparam int CLK_NS       = 100;
	localparam int RISE_NORM_NS = 410000;
	localparam int RISE_LIM_NS  = 90800;
	localparam int FALL_NORM_NS = 104000;
	localparam int FALL_LIM_NS  = 22700;
	localparam int HOLD_BASE_NS = 2670000;
	localparam int RISE_LIM_CYC  = RISE_LIM_NS / CLK_NS;
	localparam int FALL_NORM_CYC = FALL_NORM_NS / CLK_NS;
	localparam int FALL_LIM_CYC  = FALL_LIM_NS / CLK_NS;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [REG_W-1:0]  data;
	} avg_reg_wr_t;

	typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_ADJUST} avg_state_t;

endpackage : avg_pkg

// ### avg_core.sv
// ADC digital volume, sample FIFO and automatic PGA gain controller
`timescale 1ns/100ps

// ==========================================================
// Sample FIFO
module avg_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 8
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
	logic         push, pop;

	assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem[rd_q[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end

endmodule : avg_fifo

// ==========================================================
// Top level
module avg_top
	import avg_pkg::*;
#(
	parameter int W             = 16,
	parameter int FIFO_DEPTH    = 8,
	parameter int RISE_NORM_CYC = RISE_NORM_NS / CLK_NS,
	parameter int HOLD_CYC      = HOLD_BASE_NS / CLK_NS
) (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                reg_wr_en,
	input  wire avg_pkg::avg_reg_wr_t reg_wr,
	input  wire logic [6:0]          reg_rd_addr,
	output logic [8:0]               reg_rd_data,
	input  wire logic                s_valid,
	output logic                     s_ready,
	input  wire logic signed [W-1:0] s_data,
	output logic                     m_valid,
	input  wire logic                m_ready,
	output logic [W-1:0]             m_data,
	output logic [5:0]               pga_gain
);
	import avg_pkg::*;

	// ==========================================================
	// Attenuation by half-decibel count: shift per 6 dB, table within
	function automatic logic signed [W-1:0] atten(
		input logic signed [W-1:0] x,
		input logic [8:0]          att
	);
		logic [4:0]          sh;
		logic [3:0]          r;
		logic signed [W+16:0] p;
		sh = 5'(att / HALF_PER_SH);
		r  = 4'(att % HALF_PER_SH);
		p  = x * $signed({1'b0, FRAC_TAB[r]});
		p  = p >>> Q_FRAC;
		p  = p >>> sh;
		return p[W-1:0];
	endfunction : atten

	// ==========================================================
	// Registers
	logic [7:0] vol_q, vol_d;
	logic [8:0] agc1_q, agc1_d;
	logic [7:0] agc2_q, agc2_d;
	logic [8:0] agc3_q, agc3_d;
	logic [8:0] rd_q, rd_d;

	always_comb
	begin
		vol_d  = vol_q;
		agc1_d = agc1_q;
		agc2_d = agc2_q;
		agc3_d = agc3_q;
		if (reg_wr_en)
		begin
			case (reg_wr.addr)
				OFS_ADC_VOL: vol_d = reg_wr.data[7:0];
				OFS_AGC1:    agc1_d = {reg_wr.data[EN_BIT], 2'b00,
					reg_wr.data[5:0]};
				OFS_AGC2:    agc2_d = reg_wr.data[7:0];
				OFS_AGC3:    agc3_d = reg_wr.data;
				default:     vol_d = vol_q;
			endcase
		end
		case (reg_rd_addr)
			OFS_ADC_VOL: rd_d = {1'b0, vol_q};
			OFS_AGC1:    rd_d = agc1_q;
			OFS_AGC2:    rd_d = {1'b0, agc2_q};
			OFS_AGC3:    rd_d = agc3_q;
			OFS_PGA:     rd_d = {3'b000, pga_gain};
			default:     rd_d = '0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			vol_q  <= RST_VOL;
			agc1_q <= {1'b0, 2'b00, RST_CEIL, RST_FLOOR};
			agc2_q <= {RST_HOLD, RST_LEVEL};
			agc3_q <= {1'b0, RST_RISE, RST_FALL};
			rd_q   <= '0;
		end
		else
		begin
			vol_q  <= vol_d;
			agc1_q <= agc1_d;
			agc2_q <= agc2_d;
			agc3_q <= agc3_d;
			rd_q   <= rd_d;
		end
	end

	assign reg_rd_data = rd_q;

	// ==========================================================
	// Volume path into the FIFO
	logic signed [W-1:0] scaled;

	always_comb
	begin
		if (vol_q == VOL_MUTE)
			scaled = '0;
		else
			scaled = atten(s_data, VOL_TOP - {1'b0, vol_q});
	end

	avg_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (s_valid),
		.in_ready  (s_ready),
		.in_data   (scaled),
		.out_valid (m_valid),
		.out_ready (m_ready),
		.out_data  (m_data)
	);

	// ==========================================================
	// Field decode and derived limits
	logic       en, mode;
	logic [5:0] floor_code, ceil_code, cap;
	logic [3:0] lvl, hold, rise, fall;
	logic [W-1:0] thr, mag;
	logic [31:0] rise_per, fall_per, hold_per;

	assign en   = agc1_q[EN_BIT];
	assign mode = agc3_q[MODE_BIT];
	assign floor_code = {agc1_q[FLOOR_LSB +: 3], FLOOR_FILL};
	assign ceil_code  = {agc1_q[CEIL_LSB +: 3], CEIL_FILL};
	assign lvl  = agc2_q[LEVEL_LSB +: 4];
	assign hold = agc2_q[HOLD_LSB +: 4];
	assign rise = agc3_q[RISE_LSB +: 4];
	assign fall = agc3_q[FALL_LSB +: 4];

	logic [5:0] pga_q, pga_d, start_q, start_d;

	always_comb
	begin
		logic [3:0] lv, rs, fs, hs;
		lv = (lvl > LEVEL_SAT) ? LEVEL_SAT : lvl;
		rs = (rise > RATE_SAT) ? RATE_SAT : rise;
		fs = (fall > RATE_SAT) ? RATE_SAT : fall;
		hs = (hold > RATE_SAT) ? RATE_SAT : hold;
		thr = W'(atten({1'b0, {(W-1){1'b1}}},
			(LEVEL_TOP - {5'h00, lv}) * LEVEL_STEP));
		rise_per = (mode ? 32'(RISE_LIM_CYC) : 32'(RISE_NORM_CYC))
			<< rs;
		fall_per = (mode ? 32'(FALL_LIM_CYC) : 32'(FALL_NORM_CYC))
			<< fs;
		hold_per = (hs == 4'h0) ? 32'h0000_0000
			: 32'(HOLD_CYC) << (hs - 4'h1);
		cap = (mode && start_q < ceil_code) ? start_q : ceil_code;
		mag = s_data[W-1] ? W'(-s_data) : W'(s_data);
	end

	// ==========================================================
	// Gain controller
	avg_state_t  st_q, st_d;
	logic [W-1:0] peak_q, peak_d;
	logic [31:0] hcnt_q, hcnt_d, scnt_q, scnt_d;
	logic        mode_q, above;

	assign above = peak_q > thr;

	always_comb
	begin
		st_d    = st_q;
		pga_d   = pga_q;
		start_d = start_q;
		hcnt_d  = hcnt_q;
		scnt_d  = scnt_q;
		peak_d  = peak_q;
		if (s_valid && s_ready && mag > peak_q)
			peak_d = mag;
		if (en && mode && !mode_q)
			start_d = pga_q;
		case (st_q)
			ST_OFF:
			begin
				if (en)
				begin
					st_d    = ST_HOLD;
					start_d = pga_q;
					hcnt_d  = '0;
					peak_d  = '0;
				end
			end
			ST_HOLD:
			begin
				scnt_d = '0;
				if (!en)
					st_d = ST_OFF;
				else if (above || hcnt_q >= hold_per)
					st_d = ST_ADJUST;
				else
					hcnt_d = hcnt_q + 1'b1;
			end
			ST_ADJUST:
			begin
				scnt_d = scnt_q + 1'b1;
				if (!en)
					st_d = ST_OFF;
				else if (above || pga_q > cap)
				begin
					if (scnt_q + 1'b1 >= fall_per)
					begin
						if (pga_q > floor_code)
							pga_d = pga_q - 1'b1;
						scnt_d = '0;
						peak_d = '0;
						hcnt_d = '0;
						st_d   = ST_HOLD;
					end
				end
				else if (scnt_q + 1'b1 >= rise_per)
				begin
					if (pga_q < cap)
						pga_d = pga_q + 1'b1;
					scnt_d = '0;
					peak_d = '0;
				end
			end
			default: st_d = ST_OFF;
		endcase
		// Software load wins; with control off this is the only mover
		if (reg_wr_en && reg_wr.addr == OFS_PGA)
			pga_d = reg_wr.data[5:0];
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_q    <= ST_OFF;
			pga_q   <= RST_PGA;
			start_q <= RST_PGA;
			hcnt_q  <= '0;
			scnt_q  <= '0;
			peak_q  <= '0;
			mode_q  <= 1'b0;
		end
		else
		begin
			st_q    <= st_d;
			pga_q   <= pga_d;
			start_q <= start_d;
			hcnt_q  <= hcnt_d;
			scnt_q  <= scnt_d;
			peak_q  <= peak_d;
			mode_q  <= mode;
		end
	end

	assign pga_gain = pga_q;

endmodule : avg_top

// ### avg_chk.sv
// Port checker for avg_top, bound into every instance
`timescale 1ns/100ps
module avg_chk
	import avg_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic                 clk,
	input wire logic                 reset,
	input wire logic                 reg_wr_en,
	input wire avg_pkg::avg_reg_wr_t reg_wr,
	input wire logic [6:0]           reg_rd_addr,
	input wire logic [8:0]           reg_rd_data,
	input wire logic                 s_valid,
	input wire logic                 s_ready,
	input wire logic signed [W-1:0]  s_data,
	input wire logic                 m_valid,
	input wire logic                 m_ready,
	input wire logic [W-1:0]         m_data,
	input wire logic [5:0]           pga_gain
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [3:0] cnt_q, cnt_d;
	logic       en_q, en_d;
	logic [2:0] flr_q, flr_d, cel_q, cel_d;
	logic       pw;
	assign pw = reg_wr_en && reg_wr.addr == OFS_PGA;
	// Shadow fill count and limits, kept from port traffic only
	always_comb
	begin
		cnt_d = cnt_q + 4'(s_valid && s_ready) - 4'(m_valid && m_ready);
		{en_d, cel_d, flr_d} = {en_q, cel_q, flr_q};
		if (reg_wr_en && reg_wr.addr == OFS_AGC1)
			{en_d, cel_d, flr_d} = {reg_wr.data[8], reg_wr.data[5:0]};
	end
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cnt_q <= 4'h0;
			{en_q, cel_q, flr_q} <= 7'h38;
		end
		else
		begin
			cnt_q <= cnt_d;
			{en_q, cel_q, flr_q} <= {en_d, cel_d, flr_d};
		end
	end
	sequence s_wr_ctl1;
		reg_wr_en && reg_wr.addr == OFS_AGC1;
	endsequence
	sequence s_rd_ctl1;
		!reg_wr_en && reg_rd_addr == OFS_AGC1;
	endsequence
	property p_fill;
		s_ready == (cnt_q != 4'h8) && m_valid == (cnt_q != 4'h0);
	endproperty
	a_fill: assert property (p_fill)
		else $error("fifo flags disagree with fill");
	property p_stall;
		m_valid && !m_ready |=> m_valid && $stable(m_data);
	endproperty
	a_stall: assert property (p_stall)
		else $error("output word dropped while stalled");
	// Reset and software loads may jump, so both are excluded
	property p_step;
		!$past(reset) && !$past(pw) && $changed(pga_gain) |->
			pga_gain == $past(pga_gain) + 6'h1 ||
			pga_gain == $past(pga_gain) - 6'h1;
	endproperty
	a_step: assert property (p_step)
		else $error("gain moved more than one step");
	property p_off;
		$past(!en_q) && $past(!en_q, 2) && !$past(pw) |-> $stable(pga_gain);
	endproperty
	a_off: assert property (p_off)
		else $error("gain moved while control off");
	property p_load;
		pw |=> pga_gain == $past(reg_wr.data[5:0]);
	endproperty
	a_load: assert property (p_load)
		else $error("software gain not loaded");
	property p_floor;
		!$past(reset) && !$past(pw) && pga_gain < $past(pga_gain) |->
			pga_gain >= {$past(flr_q), 3'h0};
	endproperty
	a_floor: assert property (p_floor)
		else $error("gain fell below floor");
	property p_ceil;
		!$past(reset) && !$past(pw) && pga_gain > $past(pga_gain) |->
			pga_gain <= {$past(cel_q), 3'h7};
	endproperty
	a_ceil: assert property (p_ceil)
		else $error("gain rose above ceiling");
	property p_rd;
		s_wr_ctl1 ##1 s_rd_ctl1 |=>
			reg_rd_data == ($past(reg_wr.data, 2) & 9'h13F);
	endproperty
	a_rd: assert property (p_rd)
		else $error("control word read back wrong");
endmodule : avg_chk

bind avg_top avg_chk #(.W(W)) u_avg_chk (.clk(clk), .reset(reset),
	.reg_wr_en(reg_wr_en), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr),
	.reg_rd_data(reg_rd_data), .s_valid(s_valid), .s_ready(s_ready),
	.s_data(s_data), .m_valid(m_valid), .m_ready(m_ready),
	.m_data(m_data), .pga_gain(pga_gain));

// ### avg_src.sv
// Sample source and sink standing in for the ADC path and reader
`timescale 1ns/100ps
module avg_src #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         go,
	input  wire logic         stall,
	input  wire logic [W-1:0] dat,
	input  wire logic         s_ready,
	output logic              s_valid = 1'b0,
	output logic [W-1:0]      s_data = '0,
	output logic              m_ready = 1'b0
);
	// Word held until taken; idle data keeps changing
	always @(posedge clk)
	begin
		if (reset)
			s_valid <= 1'b0;
		else if (!s_valid || s_ready)
		begin
			s_valid <= go;
			s_data <= dat;
		end
		m_ready <= !stall;
	end
endmodule : avg_src

// ### avg_top_tb.sv
// Bench for avg_top: registers, sample stream and gain steps
`timescale 1ns/100ps
module avg_top_tb;
	import avg_pkg::*;
	logic               clk, reset, reg_wr_en, go, frc, rnd;
	avg_reg_wr_t        reg_wr;
	logic [6:0]         reg_rd_addr;
	logic [8:0]         reg_rd_data;
	logic               s_valid, s_ready, m_valid, m_ready;
	logic signed [15:0] s_data;
	logic [15:0]        m_data, msk;
	logic [5:0]         pga_gain;
	logic [31:0]        seed = 32'h89C06964;
	int                 err_total, checked, vol;
	logic [15:0]        exp_q[$];
	logic [7:0]         vols[4] = '{8'hFF, 8'hF3, 8'h03, 8'h00};

	avg_top #(.RISE_NORM_CYC(20), .HOLD_CYC(10)) u_avg_top (.clk(clk),
		.reset(reset), .reg_wr_en(reg_wr_en), .reg_wr(reg_wr),
		.reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
		.s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
		.m_valid(m_valid), .m_ready(m_ready), .m_data(m_data),
		.pga_gain(pga_gain));
	avg_src u_avg_src (.clk(clk), .reset(reset), .go(go),
		.stall(frc | (rnd & seed[17] & seed[18])), .dat(seed[15:0] & msk),
		.s_ready(s_ready), .s_valid(s_valid), .s_data(s_data),
		.m_ready(m_ready));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// Only whole 6 dB codes, so rounding order cannot matter
	function automatic logic [15:0] expv(input logic signed [15:0] x);
		return (vol == 0) ? 16'h0000 : 16'(x >>> ((255 - vol) / 12));
	endfunction : expv
	task automatic chk(input logic [15:0] got, input logic [15:0] e);
		checked++;
		if (got !== e)
		begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, e);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		@(posedge clk);
		reg_wr_en <= 1'b1;
		reg_wr <= '{addr: a, data: d};
		@(posedge clk);
		reg_wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_rd_addr <= a;
		@(posedge clk);
		@(negedge clk);
		chk(16'(reg_rd_data), e);
	endtask : rd
	task automatic gain(input int n, input logic [15:0] e);
		repeat (n) @(posedge clk);
		@(negedge clk);
		chk(16'(pga_gain), e);
	endtask : gain
	task automatic tally_and_finish();
		if (err_total == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) seed <= xs(seed);
	// Sampled mid-cycle, clear of the design's own edge updates
	always @(negedge clk)
	begin
		if (!reset && s_valid && s_ready)
			exp_q.push_back(expv(s_data));
		if (!reset && m_valid && m_ready && exp_q.size() > 0)
			chk(m_data, exp_q.pop_front());
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end
	initial
	begin
		{reset, reg_wr_en, reg_wr, reg_rd_addr} = '1;
		{reg_wr_en, reg_wr, reg_rd_addr, go, frc, rnd, msk} = '0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		gain(0, 16'h0010);
		rd(OFS_ADC_VOL, 16'h00FF);
		rd(OFS_AGC2, 16'h000B);
		rd(7'h10, 16'h0000);
		rd(OFS_AGC3, 16'h0032);
		rd(OFS_AGC1, 16'h0038);
		wr(OFS_AGC1, 9'h0FF);
		rd(OFS_AGC1, 16'h003F);
		msk <= 16'hFFFF;
		foreach (vols[i])
		begin
			wr(OFS_ADC_VOL, {1'b0, vols[i]});
			vol = int'(vols[i]);
			frc <= (i == 0);
			go <= 1'b1;
			repeat (12) @(posedge clk);
			@(negedge clk);
			if (i == 0)
				chk(16'(s_ready), 16'h0000);
			frc <= 1'b0;
			rnd <= 1'b1;
			repeat (40) @(posedge clk);
			{go, rnd} <= 2'h0;
			repeat (20) @(posedge clk);
		end
		chk(16'(exp_q.size()), 16'h0000);
		msk <= 16'h0000;
		go <= 1'b1;
		wr(OFS_AGC3, 9'h000);
		wr(OFS_AGC2, 9'h000);
		wr(OFS_AGC1, 9'h111);
		gain(400, 16'h0017);
		wr(OFS_AGC1, 9'h011);
		msk <= 16'hFFFF;
		gain(300, 16'h0017);
		wr(OFS_AGC3, 9'h100);
		wr(OFS_PGA, 9'h014);
		gain(0, 16'h0014);
		wr(OFS_AGC1, 9'h139);
		gain(4000, 16'h0008);
		msk <= 16'h0000;
		gain(12000, 16'h0014);
		wr(OFS_AGC3, 9'h000);
		gain(1500, 16'h003F);
		rd(OFS_PGA, 16'h003F);
		// Top hold code saturates to 10 * 512 cycles before any rise
		wr(OFS_AGC1, 9'h039);
		wr(OFS_AGC2, 9'h0F0);
		wr(OFS_PGA, 9'h010);
		wr(OFS_AGC1, 9'h139);
		gain(4000, 16'h0010);
		gain(3000, 16'h003F);
		tally_and_finish();
	end
endmodule : avg_top_tb
